// *** inc/cmpc_defines.svh ***
`ifndef CMPC_DEFINES_SVH
`define CMPC_DEFINES_SVH
// Contract
// - Listen-only receives, never drives dominant.
// - Module disabled stops all clocks.
// - Sleep keeps only register access clocks.
// - Wake interrupt needs sleep, wake enable, irq enable.
// - Stop-in-wait powers down, then restarts normally; from sleep the code returns to sleep instead.
// - Wait without stop-in-wait keeps running.
// - CPU stop powers down unless the module is disabled.
// - Sleep waits for transmit and reception end.
// - Sleep acknowledge set once sleep is active.
// - Bus-off recovery count pauses during sleep.
// - Sleep: pin recessive, no shift, no abort.
// - Wake disabled holds internal receive recessive.
// - Leave sleep on bus activity or clear.
// - Sleep request clear refused before acknowledge.
// - After wake wait eleven recessive bits.
// - Deferred actions run on wake-up.
// - Init aborts traffic, forces pin recessive.
// - Init resets control registers, opens configuration.
// - Init acknowledge after two plus three clocks.
// - Init request clear refused before acknowledge.
// - Power-down stops all; recovery unless asleep.
// - Optional low-pass filter on wake input.

// ****************************************************************
// Register map
// ****************************************************************
`define CMPC_OFS_CTRL          8'h00
`define CMPC_OFS_STAT          8'h04
`define CMPC_CTRL_SLEEP_REQ    0
`define CMPC_CTRL_INIT_REQ     1
`define CMPC_CTRL_WAKE_EN      2
`define CMPC_CTRL_STOP_IN_WAIT 3
`define CMPC_CTRL_LISTEN       4
`define CMPC_CTRL_ENABLE       5
`define CMPC_CTRL_FILT_MODE    6
`define CMPC_CTRL_WAKE_IRQ_EN  7
`define CMPC_CTRL_RESET        8'h02
`define CMPC_STAT_SLEEP_ACK    0
`define CMPC_STAT_INIT_ACK     1
`define CMPC_STAT_WAKE_FLAG    2
`define CMPC_STAT_RESYNC       3
`define CMPC_RESP_OKAY         2'h0
`define CMPC_RESP_SLVERR       2'h2
`define CMPC_RESP_DECERR       2'h3

// ****************************************************************
// Timing counts in clock cycles; resync count in bit times
// ****************************************************************
`define CMPC_INIT_BUS_CLKS     2
`define CMPC_INIT_CAN_CLKS     3
`define CMPC_INIT_DLY          (`CMPC_INIT_BUS_CLKS + `CMPC_INIT_CAN_CLKS)
`define CMPC_RESYNC_BITS       11
`define CMPC_RECOVERY_CYC      16
`define CMPC_FILT_LEN          8
`endif

// *** inc/cmpc_pkg.sv ***
package cmpc_pkg;

    typedef enum logic [3:0] {
        CMPC_DISABLED,
        CMPC_NORMAL,
        CMPC_SLEEP_PEND,
        CMPC_SLEEP,
        CMPC_RESYNC,
        CMPC_INIT_PEND,
        CMPC_INIT,
        CMPC_PDOWN,
        CMPC_RECOVER
    } cmpc_mode_t;

    typedef struct packed {
        logic wakeup_interrupt_enable;
        logic wakeup_filter_mode;
        logic module_enable;
        logic listen_only;
        logic stop_in_wait;
        logic wakeup_function_enable;
        logic init_request;
        logic sleep_request;
    } cmpc_ctrl_t;

    typedef struct packed {
        cmpc_mode_t mode;
        cmpc_ctrl_t ctrl;
        logic       sleep_acknowledge;
        logic       init_acknowledge;
        logic       wake_flag;
        logic       was_sleep;
        logic [4:0] cnt;
        logic       rx_s1;
        logic       rx_s2;
        logic       aw_have;
        logic [7:0] aw_addr;
        logic       w_have;
        logic [7:0] wdata;
        logic       wstrb0;
        logic       bvalid;
        logic [1:0] bresp;
        logic       rvalid;
        logic [7:0] rdata;
        logic [1:0] rresp;
        logic       restart;
        logic       deferred;
        logic       irq;
    } cmpc_state_t;

endpackage : cmpc_pkg

// *** src/cmpc_wake_filter.sv ***
`include "cmpc_defines.svh"

// ****************************************************************
// Bus activity detector with optional low-pass filter
// ****************************************************************
module cmpc_wake_filter
    import cmpc_pkg::*;
#(
    parameter int FILT_LEN = `CMPC_FILT_LEN
)
(
    input  wire logic mclk_i,
    input  wire logic resetn_i,
    input  wire logic rx_i,
    input  wire logic arm_i,
    input  wire logic filter_en_i,
    output logic      activity_o
);

    localparam int CW = $clog2(FILT_LEN + 1);

    typedef struct packed {
        logic [CW-1:0] cnt;
    } cmpc_filt_state_t;

    cmpc_filt_state_t s;
    cmpc_filt_state_t n;

    // A dominant level must persist for the full filter length to count.
    always_comb
    begin
        n = s;
        if (!arm_i || rx_i)
            n.cnt = '0;
        else if (s.cnt != CW'(FILT_LEN))
            n.cnt = s.cnt + CW'(1);
    end

    always_ff @(posedge mclk_i)
    begin
        if (!resetn_i)
            s <= '0;
        else
            s <= n;
    end

    assign activity_o = arm_i && !rx_i
                        && (!filter_en_i || s.cnt == CW'(FILT_LEN - 1));

    a_filter_hold : assert property (@(posedge mclk_i) disable iff (!resetn_i)
        activity_o && filter_en_i |-> $past(!rx_i && arm_i, FILT_LEN - 1))
        else $error("Filtered wake-up without a long enough dominant level.");

endmodule : cmpc_wake_filter

// *** src/cmpc_mode_ctrl.sv ***
// The implementer's own choices: the AXI4-Lite interface to the registers and the placing of the registers.
`include "cmpc_defines.svh"

// ****************************************************************
// Operating mode and low-power control with AXI4-Lite registers
// ****************************************************************
module cmpc_mode_ctrl
    import cmpc_pkg::*;
(
    input  wire logic       mclk_i,
    input  wire logic       resetn_i,
    input  wire logic       s_axi_awvalid,
    output logic            s_axi_awready,
    input  wire logic [7:0] s_axi_awaddr,
    input  wire logic       s_axi_wvalid,
    output logic            s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0] s_axi_wstrb,
    output logic            s_axi_bvalid,
    input  wire logic       s_axi_bready,
    output logic [1:0]      s_axi_bresp,
    input  wire logic       s_axi_arvalid,
    output logic            s_axi_arready,
    input  wire logic [7:0] s_axi_araddr,
    output logic            s_axi_rvalid,
    input  wire logic       s_axi_rready,
    output logic [31:0]     s_axi_rdata,
    output logic [1:0]      s_axi_rresp,
    input  wire logic       cpu_wait_i,
    input  wire logic       cpu_stop_i,
    input  wire logic       bus_rx_pin_i,
    output logic            bus_tx_pin_o,
    input  wire logic       core_tx_i,
    output logic            core_rx_o,
    input  wire logic       core_rx_busy_i,
    input  wire logic [2:0] tx_buffer_empty_flag_i,
    input  wire logic       bus_off_i,
    input  wire logic       bit_tick_i,
    output logic            core_clk_en_o,
    output logic            reg_clk_en_o,
    output logic            core_abort_o,
    output logic            core_restart_o,
    output logic            deferred_go_o,
    output logic            rx_shift_allow_o,
    output logic            abort_allow_o,
    output logic            busoff_count_en_o,
    output logic            init_regs_reset_o,
    output logic            config_wr_en_o,
    output logic            wakeup_irq_o
);

    cmpc_state_t s;
    cmpc_state_t n;
    logic        activity;
    logic        arm;
    logic        pdown_req;
    logic        do_wr;

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [1:0] cmpc_sel(input logic [7:0] addr);
        if (addr == `CMPC_OFS_CTRL)
            return 2'h0;
        if (addr == `CMPC_OFS_STAT)
            return 2'h1;
        return 2'h3;
    endfunction : cmpc_sel

    function automatic cmpc_ctrl_t cmpc_ctrl_unpack(input logic [7:0] b);
        cmpc_ctrl_t c;
        c.sleep_request           = b[`CMPC_CTRL_SLEEP_REQ];
        c.init_request            = b[`CMPC_CTRL_INIT_REQ];
        c.wakeup_function_enable  = b[`CMPC_CTRL_WAKE_EN];
        c.stop_in_wait            = b[`CMPC_CTRL_STOP_IN_WAIT];
        c.listen_only             = b[`CMPC_CTRL_LISTEN];
        c.module_enable           = b[`CMPC_CTRL_ENABLE];
        c.wakeup_filter_mode      = b[`CMPC_CTRL_FILT_MODE];
        c.wakeup_interrupt_enable = b[`CMPC_CTRL_WAKE_IRQ_EN];
        return c;
    endfunction : cmpc_ctrl_unpack

    function automatic logic [7:0] cmpc_ctrl_pack(input cmpc_ctrl_t c);
        logic [7:0] b;
        b = 8'h00;
        b[`CMPC_CTRL_SLEEP_REQ]    = c.sleep_request;
        b[`CMPC_CTRL_INIT_REQ]     = c.init_request;
        b[`CMPC_CTRL_WAKE_EN]      = c.wakeup_function_enable;
        b[`CMPC_CTRL_STOP_IN_WAIT] = c.stop_in_wait;
        b[`CMPC_CTRL_LISTEN]       = c.listen_only;
        b[`CMPC_CTRL_ENABLE]       = c.module_enable;
        b[`CMPC_CTRL_FILT_MODE]    = c.wakeup_filter_mode;
        b[`CMPC_CTRL_WAKE_IRQ_EN]  = c.wakeup_interrupt_enable;
        return b;
    endfunction : cmpc_ctrl_pack

    // ****************************************************************
    // Wake-up detection
    // ****************************************************************
    assign arm = s.ctrl.wakeup_function_enable
                 && (s.mode == CMPC_SLEEP || (s.mode == CMPC_PDOWN && s.was_sleep));

    cmpc_wake_filter #(
        .FILT_LEN (`CMPC_FILT_LEN)
    ) u_wake_filter (
        .mclk_i      (mclk_i),
        .resetn_i    (resetn_i),
        .rx_i        (s.rx_s2),
        .arm_i       (arm),
        .filter_en_i (s.ctrl.wakeup_filter_mode),
        .activity_o  (activity)
    );

    // ****************************************************************
    // Next state
    // ****************************************************************
    assign pdown_req = cpu_stop_i || (cpu_wait_i && s.ctrl.stop_in_wait);
    assign do_wr     = s.aw_have && s.w_have && !s.bvalid;

    always_comb
    begin
        cmpc_ctrl_t w;
        w = cmpc_ctrl_unpack(s.wdata);
        n = s;
        n.rx_s1    = bus_rx_pin_i;
        n.rx_s2    = s.rx_s1;
        n.restart  = 1'b0;
        n.deferred = 1'b0;
        n.irq      = 1'b0;

        // Write channel: address and data are taken in either order.
        if (s_axi_awvalid && s_axi_awready)
        begin
            n.aw_have = 1'b1;
            n.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            n.w_have = 1'b1;
            n.wdata  = s_axi_wdata[7:0];
            n.wstrb0 = s_axi_wstrb[0];
        end
        if (s.bvalid && s_axi_bready)
            n.bvalid = 1'b0;
        if (do_wr)
        begin
            n.aw_have = 1'b0;
            n.w_have  = 1'b0;
            n.bvalid  = 1'b1;
            n.bresp   = `CMPC_RESP_OKAY;
            if (s.mode == CMPC_PDOWN)
                n.bresp = `CMPC_RESP_SLVERR;
            else if (cmpc_sel(s.aw_addr) == 2'h3)
                n.bresp = `CMPC_RESP_DECERR;
            else if (s.wstrb0 && cmpc_sel(s.aw_addr) == 2'h0)
            begin
                n.ctrl = w;
                if (!s.sleep_acknowledge && s.ctrl.sleep_request)
                    n.ctrl.sleep_request = 1'b1;
                if (!s.init_acknowledge && s.ctrl.init_request)
                    n.ctrl.init_request = 1'b1;
            end
            else if (s.wstrb0 && s.wdata[`CMPC_STAT_WAKE_FLAG])
                n.wake_flag = 1'b0;
        end

        // Read channel.
        if (s.rvalid && s_axi_rready)
            n.rvalid = 1'b0;
        if (s_axi_arvalid && s_axi_arready)
        begin
            n.rvalid = 1'b1;
            n.rresp  = `CMPC_RESP_OKAY;
            n.rdata  = 8'h00;
            if (s.mode == CMPC_PDOWN)
                n.rresp = `CMPC_RESP_SLVERR;
            else if (cmpc_sel(s_axi_araddr) == 2'h0)
                n.rdata = cmpc_ctrl_pack(s.ctrl);
            else if (cmpc_sel(s_axi_araddr) == 2'h1)
            begin
                n.rdata[`CMPC_STAT_SLEEP_ACK] = s.sleep_acknowledge;
                n.rdata[`CMPC_STAT_INIT_ACK]  = s.init_acknowledge;
                n.rdata[`CMPC_STAT_WAKE_FLAG] = s.wake_flag;
                n.rdata[`CMPC_STAT_RESYNC]    = (s.mode == CMPC_RESYNC);
            end
            else
                n.rresp = `CMPC_RESP_DECERR;
        end

        // Mode sequencing; hardware events win over software clears.
        if (!s.ctrl.module_enable)
        begin
            n.mode              = CMPC_DISABLED;
            n.sleep_acknowledge = 1'b0;
            n.init_acknowledge  = 1'b0;
        end
        else if (pdown_req && s.mode != CMPC_PDOWN && s.mode != CMPC_DISABLED)
        begin
            n.was_sleep = (s.mode == CMPC_SLEEP);
            n.mode      = CMPC_PDOWN;
        end
        else
        begin
            unique case (s.mode)
                CMPC_DISABLED:
                begin
                    n.cnt  = 5'h00;
                    n.mode = s.ctrl.init_request ? CMPC_INIT_PEND : CMPC_RESYNC;
                end
                CMPC_NORMAL:
                begin
                    n.cnt = 5'h00;
                    if (s.ctrl.init_request)
                        n.mode = CMPC_INIT_PEND;
                    else if (s.ctrl.sleep_request)
                        n.mode = CMPC_SLEEP_PEND;
                end
                CMPC_SLEEP_PEND:
                begin
                    n.cnt = 5'h00;
                    if (s.ctrl.init_request)
                        n.mode = CMPC_INIT_PEND;
                    else if ((&tx_buffer_empty_flag_i) && !core_rx_busy_i)
                    begin
                        n.mode              = CMPC_SLEEP;
                        n.sleep_acknowledge = 1'b1;
                    end
                end
                CMPC_SLEEP:
                begin
                    n.cnt = 5'h00;
                    if (s.ctrl.init_request)
                        n.mode = CMPC_INIT_PEND;
                    else if (!s.ctrl.sleep_request)
                    begin
                        n.mode              = CMPC_RESYNC;
                        n.sleep_acknowledge = 1'b0;
                    end
                    else if (activity)
                    begin
                        n.mode                = CMPC_RESYNC;
                        n.sleep_acknowledge   = 1'b0;
                        n.ctrl.sleep_request  = 1'b0;
                        n.wake_flag           = 1'b1;
                        n.irq = s.ctrl.wakeup_interrupt_enable;
                    end
                end
                CMPC_RESYNC:
                begin
                    if (s.ctrl.init_request)
                    begin
                        n.mode = CMPC_INIT_PEND;
                        n.cnt  = 5'h00;
                    end
                    else if (bit_tick_i && !s.rx_s2)
                        n.cnt = 5'h00;
                    else if (bit_tick_i && s.cnt == 5'(`CMPC_RESYNC_BITS - 1))
                    begin
                        n.mode     = CMPC_NORMAL;
                        n.deferred = 1'b1;
                    end
                    else if (bit_tick_i)
                        n.cnt = s.cnt + 5'h01;
                end
                CMPC_INIT_PEND:
                begin
                    n.cnt = s.cnt + 5'h01;
                    if (s.cnt == 5'(`CMPC_INIT_DLY - 1))
                    begin
                        n.mode             = CMPC_INIT;
                        n.init_acknowledge = 1'b1;
                    end
                end
                CMPC_INIT:
                begin
                    n.cnt                          = 5'h00;
                    n.ctrl.sleep_request           = 1'b0;
                    n.ctrl.wakeup_function_enable  = 1'b0;
                    n.ctrl.stop_in_wait            = 1'b0;
                    n.ctrl.wakeup_interrupt_enable = 1'b0;
                    n.sleep_acknowledge            = 1'b0;
                    n.wake_flag                    = 1'b0;
                    if (!s.ctrl.init_request)
                    begin
                        n.mode             = CMPC_RESYNC;
                        n.init_acknowledge = 1'b0;
                    end
                end
                CMPC_PDOWN:
                begin
                    n.cnt = 5'h00;
                    if (activity)
                    begin
                        n.wake_flag = 1'b1;
                        n.irq       = s.ctrl.wakeup_interrupt_enable;
                    end
                    if (!pdown_req)
                        n.mode = s.was_sleep ? CMPC_SLEEP : CMPC_RECOVER;
                end
                CMPC_RECOVER:
                begin
                    n.cnt = s.cnt + 5'h01;
                    if (s.cnt == 5'(`CMPC_RECOVERY_CYC - 1))
                    begin
                        n.mode    = CMPC_NORMAL;
                        n.restart = 1'b1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (!resetn_i)
        begin
            s      <= '0;
            s.mode <= CMPC_DISABLED;
            s.ctrl <= cmpc_ctrl_t'(`CMPC_CTRL_RESET);
            s.rx_s1 <= 1'b1;
            s.rx_s2 <= 1'b1;
        end
        else
            s <= n;
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign s_axi_awready = !s.aw_have && !s.bvalid;
    assign s_axi_wready  = !s.w_have && !s.bvalid;
    assign s_axi_bvalid  = s.bvalid;
    assign s_axi_bresp   = s.bresp;
    assign s_axi_arready = !s.rvalid;
    assign s_axi_rvalid  = s.rvalid;
    assign s_axi_rdata   = {24'h000000, s.rdata};
    assign s_axi_rresp   = s.rresp;

    assign core_clk_en_o = s.mode inside {CMPC_NORMAL, CMPC_SLEEP_PEND, CMPC_RESYNC,
                                          CMPC_INIT_PEND, CMPC_RECOVER};
    assign reg_clk_en_o  = !(s.mode inside {CMPC_DISABLED, CMPC_PDOWN});
    assign bus_tx_pin_o  = (s.mode inside {CMPC_NORMAL, CMPC_SLEEP_PEND})
                           && !s.ctrl.listen_only ? core_tx_i : 1'b1;
    assign core_rx_o     = (s.mode inside {CMPC_SLEEP, CMPC_PDOWN})
                           && !s.ctrl.wakeup_function_enable ? 1'b1 :
                           s.ctrl.listen_only ? (s.rx_s2 & core_tx_i) : s.rx_s2;
    assign core_abort_o      = s.mode inside {CMPC_INIT_PEND, CMPC_INIT, CMPC_PDOWN};
    assign rx_shift_allow_o  = s.mode != CMPC_SLEEP;
    assign abort_allow_o     = s.mode != CMPC_SLEEP;
    assign busoff_count_en_o = bus_off_i
                               && (s.mode inside {CMPC_NORMAL, CMPC_SLEEP_PEND, CMPC_RESYNC});
    assign init_regs_reset_o = s.mode == CMPC_INIT;
    assign config_wr_en_o    = s.mode == CMPC_INIT && s.init_acknowledge;
    assign core_restart_o    = s.restart;
    assign deferred_go_o     = s.deferred;
    assign wakeup_irq_o      = s.irq;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    a_listen_tx_recessive : assert property (@(posedge mclk_i) disable iff (!resetn_i)
        s.ctrl.listen_only |-> bus_tx_pin_o)
        else $error("Dominant level driven in listen-only mode.");

    a_disable_clocks_off : assert property (@(posedge mclk_i) disable iff (!resetn_i)
        !s.ctrl.module_enable |=> !core_clk_en_o && !reg_clk_en_o)
        else $error("Clocks running while module disabled.");

    a_sleep_reg_clock : assert property (@(posedge mclk_i) disable iff (!resetn_i)
        s.mode == CMPC_SLEEP |-> !core_clk_en_o && reg_clk_en_o && bus_tx_pin_o)
        else $error("Wrong clocks or pin in sleep.");

    a_wake_irq_cause : assert property (@(posedge mclk_i) disable iff (!resetn_i)
        wakeup_irq_o |-> $past(s.ctrl.wakeup_interrupt_enable && s.sleep_acknowledge
                               && s.ctrl.sleep_request && s.ctrl.wakeup_function_enable))
        else $error("Wake-up interrupt without its enabling conditions.");

    a_stop_to_pdown : assert property (@(posedge mclk_i) disable iff (!resetn_i)
        cpu_stop_i && s.ctrl.module_enable && s.mode != CMPC_DISABLED
        |=> s.mode == CMPC_PDOWN)
        else $error("CPU stop did not power down.");

    a_sleep_waits_tx : assert property (@(posedge mclk_i) disable iff (!resetn_i)
        s.mode == CMPC_SLEEP_PEND && !(&tx_buffer_empty_flag_i) |=> !s.sleep_acknowledge)
        else $error("Sleep acknowledged with transmit pending.");

    a_sleep_clear_lock : assert property (@(posedge mclk_i) disable iff (!resetn_i)
        $fell(s.ctrl.sleep_request) |-> $past(s.sleep_acknowledge) || $past(s.mode == CMPC_INIT))
        else $error("Sleep request cleared before acknowledge.");

    a_init_ack_delay : assert property (@(posedge mclk_i) disable iff (!resetn_i)
        $rose(s.init_acknowledge) |-> $past(s.mode == CMPC_INIT_PEND, 5)
                                      && $past(s.mode == CMPC_INIT_PEND, 1))
        else $error("Init acknowledge delay is not five cycles.");

    a_init_tx_recess : assert property (@(posedge mclk_i) disable iff (!resetn_i)
        s.ctrl.init_request && s.mode != CMPC_DISABLED |=> bus_tx_pin_o)
        else $error("Transmit pin not recessive on init request.");

endmodule : cmpc_mode_ctrl

// *** test/cmpc_can_node.sv ***
module cmpc_can_node
(
    input  wire logic mclk_i,
    input  wire logic dut_tx_i,
    input  wire logic dom_i,
    output logic      rx_o,
    output logic      tick_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] div_q = 3'h0;
    // The bus is a wired AND, so one dominant node pulls every receiver low.
    assign rx_o   = dut_tx_i & ~dom_i;
    assign tick_o = (div_q == 3'h7);
    always @(posedge mclk_i) div_q <= div_q + 3'h1;
endmodule : cmpc_can_node

// *** test/testbench.sv ***
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        mclk_i, resetn_i, awv, awr, wv, wr, bv, bry, arv, arr, rv, rry, cw, cs, tx;
    logic        ctx, crx, busy, boff, tick, cke, rke, rst, dg, rsa, aa, irs, cwe, irq, dom, brx;
    logic [7:0]  awa, ara;
    logic [31:0] wd, rd, rdv;
    logic [3:0]  ws;
    logic [2:0]  txe;
    logic [1:0]  br, rr, rsp;
    logic        bce, abt;
    int          fail_count = 0, n_checks = 0, cyc = 0, seed = 32'h38CCBD24;
    cmpc_mode_ctrl i_cmpc_mode_ctrl (.mclk_i(mclk_i), .resetn_i(resetn_i),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_wvalid(wv),
        .s_axi_wready(wr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_bvalid(bv),
        .s_axi_bready(bry), .s_axi_bresp(br), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rry), .s_axi_rdata(rd),
        .s_axi_rresp(rr), .cpu_wait_i(cw), .cpu_stop_i(cs), .bus_rx_pin_i(brx),
        .bus_tx_pin_o(tx), .core_tx_i(ctx), .core_rx_o(crx), .core_rx_busy_i(busy),
        .tx_buffer_empty_flag_i(txe), .bus_off_i(boff), .bit_tick_i(tick),
        .core_clk_en_o(cke), .reg_clk_en_o(rke), .core_abort_o(abt), .core_restart_o(rst),
        .deferred_go_o(dg), .rx_shift_allow_o(rsa), .abort_allow_o(aa),
        .busoff_count_en_o(bce), .init_regs_reset_o(irs), .config_wr_en_o(cwe),
        .wakeup_irq_o(irq));
    cmpc_can_node i_cmpc_can_node (.mclk_i(mclk_i), .dut_tx_i(tx), .dom_i(dom), .rx_o(brx),
        .tick_o(tick));
    initial
    begin
        mclk_i = 1'b0;
        forever #25 mclk_i = ~mclk_i;
    end
    always @(posedge mclk_i)
        if (cyc++ == 4000) finish_test(1'b1);
    task automatic finish_test(input bit hung);
        fail_count += int'(hung);
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : finish_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wrr(input logic [7:0] a, input logic [7:0] d);
        bit pa = 1'b1, pw = 1'b1, ta, tw;
        @(posedge mclk_i);
        awa <= a;
        wd <= {24'($random(seed)), d};
        awv <= 1'b1;
        wv <= 1'b1;
        while (pa || pw)
        begin
            @(negedge mclk_i);
            ta = pa & awr;
            tw = pw & wr;
            @(posedge mclk_i);
            if (ta) awv <= 1'b0;
            if (tw) wv <= 1'b0;
            pa = pa & ~ta;
            pw = pw & ~tw;
        end
        do @(negedge mclk_i); while (!bv);
        rsp = br;
        @(posedge mclk_i);
    endtask : wrr
    task automatic rdr(input logic [7:0] a);
        @(posedge mclk_i);
        ara <= a;
        arv <= 1'b1;
        do @(negedge mclk_i); while (!arr);
        @(posedge mclk_i);
        arv <= 1'b0;
        do @(negedge mclk_i); while (!rv);
        rdv = rd;
        rsp = rr;
        @(posedge mclk_i);
    endtask : rdr
    task automatic poll(input int b, input logic v);
        do rdr(8'h04); while (rdv[b] !== v);
    endtask : poll
    initial
    begin
        {resetn_i, awv, wv, arv, cw, cs, busy, boff, dom, awa, ara, wd} = '0;
        {ws, txe, bry, rry, ctx} = {4'hF, 3'h7, 3'h7};
        repeat (2) @(posedge mclk_i);
        resetn_i <= 1'b1;
        rdr(8'h00);
        chk(rdv, 32'h0000_0002);
        chk({tx, cke, rke}, 3'h4);
        rdr(8'h10);
        chk(rsp, 2'h3);
        $display("reset test done");
        wrr(8'h00, 8'h22);
        wrr(8'h00, 8'h20);
        rdr(8'h00);
        chk(rdv, 32'h0000_0022);
        poll(1, 1'b1);
        chk({tx, cwe, irs, cke, abt}, 5'h1D);
        wrr(8'h00, 8'h20);
        do @(negedge mclk_i); while (!dg);
        chk(cke, 1'b1);
        wrr(8'h00, 8'h30);
        ctx <= 1'b0;
        @(negedge mclk_i);
        chk({tx, crx}, 2'h2);
        @(posedge mclk_i);
        ctx <= 1'b1;
        boff <= 1'b1;
        $display("init test done");
        wrr(8'h00, 8'h21);
        poll(0, 1'b1);
        chk({cke, rke, rsa, aa, tx, bce}, 6'h12);
        dom <= 1'b1;
        poll(0, 1'b1);
        @(negedge mclk_i);
        chk(crx, 1'b1);
        $display("sleep test done");
        wrr(8'h00, 8'hE5);
        do @(negedge mclk_i); while (!irq);
        @(posedge mclk_i);
        dom <= 1'b0;
        rdr(8'h00);
        chk(rdv[0], 1'b0);
        rdr(8'h04);
        chk(rdv[3:2], 2'h3);
        do @(negedge mclk_i); while (!dg);
        chk(bce, 1'b1);
        $display("wake test done");
        @(posedge mclk_i);
        cw <= 1'b1;
        rdr(8'h00);
        chk({rsp, cke}, 3'h1);
        wrr(8'h00, 8'h28);
        rdr(8'h00);
        chk(rsp, 2'h2);
        cw <= 1'b0;
        do @(negedge mclk_i); while (!rst);
        @(posedge mclk_i);
        cs <= 1'b1;
        repeat (2) @(posedge mclk_i);
        rdr(8'h00);
        chk({rsp, tx, abt}, 4'hB);
        cs <= 1'b0;
        do @(negedge mclk_i); while (!rst);
        $display("stop test done");
        finish_test(1'b0);
    end
endmodule : testbench
